/* verilog/gpw_pkg.sv */
// Purpose: Shared constants for the two general-purpose ports and pin-change wake.
// Assumes: Core instruction clock mclk at 100 MHz; one instruction per clock.
// Notes:   Register offsets are file-register addresses seen by the core.
package gpw_pkg;
  // Clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 10;
  // File-register addresses of the status and both port registers.
  localparam logic [4:0] ADDR_STATUS = 5'h03;
  localparam logic [4:0] ADDR_NARROW = 5'h05;
  localparam logic [4:0] ADDR_WIDE   = 5'h06;
  // Selectors carried by the direction-load instruction.
  localparam logic [2:0] SEL_NARROW_DIR = 3'h5;
  localparam logic [2:0] SEL_WIDE_DIR   = 3'h6;
  localparam logic [2:0] SEL_OPTION     = 3'h7;
  // Port widths.
  localparam int NARROW_W = 4;
  localparam int WIDE_W   = 8;
  // Status flag bit positions.
  localparam int STAT_WAKE_FLAG  = 7;
  localparam int STAT_TIMEOUT    = 4;
  localparam int STAT_POWER_DOWN = 3;
  // Option register layout and power-on value.
  localparam int          OPT_W      = 6;
  localparam int          OPT_WAKE_DIS = 5;
  localparam logic [5:0]  OPT_RESET  = 6'h3f;
  // Direction register reset value (all inputs).
  localparam logic [7:0]  DIR_RESET  = 8'hff;
  // Output latch power-on value.
  localparam logic [7:0]  LATCH_RESET = 8'h00;
  // Monitored low wake pins and the slow-ramp pin index.
  localparam int WAKE_LOW_N = 4;
  localparam int RAMP_PIN   = 7;
  // Slow-ramp pin must stay high this long before it counts as a wake.
  localparam int RAMP_FILT_NS = 50;
  localparam int RAMP_FILT_CYC = (RAMP_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Sleep controller states, one-hot.
  typedef enum logic [2:0] {
    ST_RUN   = 3'h1,
    ST_SLEEP = 3'h2,
    ST_WAKE  = 3'h4
  } gpw_state_t;
endpackage

/* verilog/gpw_sync.sv */
// Purpose: Two-stage synchroniser for a bus of independent pin levels.
// Assumes: Each bit is an unrelated level; no bus coherency is promised.
// Notes:   Only the second stage is visible outside.
`timescale 1ns/10ps
module gpw_sync #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // First stage, read only by the second stage.
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  // Second stage, the safe copy.
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // Next values simply shift the pin sample along.
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // Both stages clear to zero under reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

/* verilog/gpw_port.sv */
// Purpose: One I/O port: output latches, direction bits and pad drive.
// Assumes: Writes arrive as single-cycle strobes from the core.
// Notes:   Direction bits return to input on every device reset.
`timescale 1ns/10ps
module gpw_port #(
  parameter int W = 8
) (
  input  wire logic         mclk,
  input  wire logic         rst_n,
  input  wire logic         dev_reset,
  input  wire logic         latch_wr,
  input  wire logic [W-1:0] latch_data,
  input  wire logic         dir_ld,
  input  wire logic [W-1:0] dir_data,
  output logic      [W-1:0] dir,
  output logic      [W-1:0] pad_out,
  output logic      [W-1:0] pad_oe
);
  // Output data latches.
  logic [W-1:0] latch_r;
  logic [W-1:0] latch_nxt;
  // Direction bits, one means input.
  logic [W-1:0] dir_r;
  logic [W-1:0] dir_nxt;

  // Latches hold until rewritten; direction loads take the whole word.
  always_comb begin
    latch_nxt = latch_r;
    if (latch_wr) begin
      latch_nxt = latch_data;
    end
    dir_nxt = dir_r;
    if (dev_reset) begin
      dir_nxt = gpw_pkg::DIR_RESET[W-1:0];
    end else if (dir_ld) begin
      dir_nxt = dir_data;
    end
  end

  // Registers; latches keep their content over non-power-on resets.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= gpw_pkg::LATCH_RESET[W-1:0];
      dir_r   <= gpw_pkg::DIR_RESET[W-1:0];
    end else begin
      latch_r <= latch_nxt;
      dir_r   <= dir_nxt;
    end
  end

  assign pad_oe  = ~dir_r;
  assign pad_out = latch_r;
  assign dir     = dir_r;
endmodule

/* verilog/gpw_top.sv */
// What this block does
// - Port reads return pin levels, not latches
// - Every reset sets all direction bits
// - Narrow port: four bits, upper read zero
// - Wide port: eight bits, latch and direction
// - Sleep entry captures four low wake pins
// - Monitored change in sleep resets device
// - Pin-change wake clears the wake flag
// - Top wide pin wakes on slow rise
// - Option bit switches pin-change wake
// - Only input pins can cause wake
// - Direction load copies word; one means input
// - Inputs unlatched; output latches hold value
// - Each pin individually input or output
// - Bit set/clear rewrite all latches
// - Writes end cycle, reads sample start
// - Three flags encode last reset cause
// - Six-bit write-only option via direction load
// - Sleep sets wake flag, bit seven
//
// Purpose: Two I/O ports with status flags and pin-change wake from sleep.
// Assumes: rst_n is the power-on reset; other resets come in as dev_reset_req.
// Notes:   Read data appears one clock after the read strobe.
`timescale 1ns/10ps
module gpw_top #(
  parameter int RAMP_FILT = gpw_pkg::RAMP_FILT_CYC
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       dev_reset_req,
  input  wire logic [4:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] core_status_bits,
  input  wire logic       dir_load,
  input  wire logic [2:0] dir_sel,
  input  wire logic [7:0] work_reg,
  input  wire logic       sleep_exec,
  input  wire logic       clrwdt_exec,
  input  wire logic       wdt_timeout,
  input  wire logic [3:0] narrow_pins_in,
  output logic      [3:0] narrow_pins_out,
  output logic      [3:0] narrow_pins_oe,
  input  wire logic [7:0] wide_pins_in,
  output logic      [7:0] wide_pins_out,
  output logic      [7:0] wide_pins_oe,
  output logic      [5:0] feature_options,
  output logic            asleep,
  output logic            wake_reset
);
  // Synchronised pin levels.
  logic [3:0] narrow_sync;
  logic [7:0] wide_sync;
  // Direction words of both ports.
  logic [3:0] narrow_dir;
  logic [7:0] wide_dir;
  // Port strobes decoded from the core.
  logic       narrow_wr;
  logic       wide_wr;
  logic       narrow_dir_ld;
  logic       wide_dir_ld;
  logic       opt_ld;
  // Reset to the port direction bits from any cause.
  logic       any_reset;
  // Status flags, set at power-on.
  logic       wake_flag_r;
  logic       wake_flag_nxt;
  logic       timeout_r;
  logic       timeout_nxt;
  logic       power_down_r;
  logic       power_down_nxt;
  // Write-only option register.
  logic [5:0] opt_r;
  logic [5:0] opt_nxt;
  // Read data register.
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  // Sleep controller state and captured reference levels.
  gpw_pkg::gpw_state_t state_r;
  gpw_pkg::gpw_state_t state_nxt;
  logic [3:0] ref_r;
  logic [3:0] ref_nxt;
  // Slow-ramp detector: armed once low seen, and a high-time counter.
  logic       armed_r;
  logic       armed_nxt;
  logic [7:0] ramp_cnt_r;
  logic [7:0] ramp_cnt_nxt;
  // Wake causes found this cycle.
  logic       low_change;
  logic       ramp_wake;
  logic       wake_hit;

  gpw_sync #(
    .W (gpw_pkg::NARROW_W)
  ) u_sync_narrow (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (narrow_pins_in),
    .sync_out (narrow_sync)
  );

  gpw_sync #(
    .W (gpw_pkg::WIDE_W)
  ) u_sync_wide (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (wide_pins_in),
    .sync_out (wide_sync)
  );

  // Decode of port writes and direction-load selectors.
  always_comb begin
    narrow_wr     = reg_wr && (reg_addr == gpw_pkg::ADDR_NARROW);
    wide_wr       = reg_wr && (reg_addr == gpw_pkg::ADDR_WIDE);
    narrow_dir_ld = dir_load && (dir_sel == gpw_pkg::SEL_NARROW_DIR);
    wide_dir_ld   = dir_load && (dir_sel == gpw_pkg::SEL_WIDE_DIR);
    opt_ld        = dir_load && (dir_sel == gpw_pkg::SEL_OPTION);
    any_reset     = dev_reset_req || wake_reset;
  end

  gpw_port #(
    .W (gpw_pkg::NARROW_W)
  ) u_port_narrow (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .dev_reset  (any_reset),
    .latch_wr   (narrow_wr),
    .latch_data (reg_wdata[3:0]),
    .dir_ld     (narrow_dir_ld),
    .dir_data   (work_reg[3:0]),
    .dir        (narrow_dir),
    .pad_out    (narrow_pins_out),
    .pad_oe     (narrow_pins_oe)
  );

  gpw_port #(
    .W (gpw_pkg::WIDE_W)
  ) u_port_wide (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .dev_reset  (any_reset),
    .latch_wr   (wide_wr),
    .latch_data (reg_wdata),
    .dir_ld     (wide_dir_ld),
    .dir_data   (work_reg),
    .dir        (wide_dir),
    .pad_out    (wide_pins_out),
    .pad_oe     (wide_pins_oe)
  );

  // Option register: only a power-on reset restores it.
  always_comb begin
    opt_nxt = opt_r;
    if (opt_ld) begin
      opt_nxt = work_reg[5:0];
    end
  end

  // Option register storage.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opt_r <= gpw_pkg::OPT_RESET;
    end else begin
      opt_r <= opt_nxt;
    end
  end

  // Register read path; the core builds read-modify-write on top of it.
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        gpw_pkg::ADDR_NARROW: begin
          rdata_nxt = {4'h0, narrow_sync};
        end
        gpw_pkg::ADDR_WIDE: begin
          rdata_nxt = wide_sync;
        end
        // Status merges core bits with the three reset-cause flags.
        gpw_pkg::ADDR_STATUS: begin
          rdata_nxt = core_status_bits;
          rdata_nxt[gpw_pkg::STAT_WAKE_FLAG]  = wake_flag_r;
          rdata_nxt[gpw_pkg::STAT_TIMEOUT]    = timeout_r;
          rdata_nxt[gpw_pkg::STAT_POWER_DOWN] = power_down_r;
        end
        // Any other address reads as zero.
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // Read data register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // Wake detection, active only while asleep with the feature enabled.
  always_comb begin
    low_change = |((wide_sync[3:0] ^ ref_r) & wide_dir[3:0]);
    ramp_wake  = armed_r && wide_dir[gpw_pkg::RAMP_PIN]
                 && (ramp_cnt_r >= 8'(RAMP_FILT));
    wake_hit   = (state_r == gpw_pkg::ST_SLEEP) && !opt_r[gpw_pkg::OPT_WAKE_DIS]
                 && (low_change || ramp_wake);
  end

  // Sleep controller next state and detector bookkeeping.
  always_comb begin
    state_nxt    = state_r;
    ref_nxt      = ref_r;
    armed_nxt    = armed_r;
    ramp_cnt_nxt = ramp_cnt_r;
    case (state_r)
      gpw_pkg::ST_RUN: begin
        if (sleep_exec && !dev_reset_req) begin
          ref_nxt      = wide_sync[3:0];
          armed_nxt    = 1'b0;
          ramp_cnt_nxt = 8'h00;
          state_nxt    = gpw_pkg::ST_SLEEP;
        end
      end
      gpw_pkg::ST_SLEEP: begin
        // The ramp pin must first be seen low, then stay high long enough.
        if (!wide_sync[gpw_pkg::RAMP_PIN]) begin
          armed_nxt    = 1'b1;
          ramp_cnt_nxt = 8'h00;
        end else if (ramp_cnt_r != 8'hff) begin
          ramp_cnt_nxt = ramp_cnt_r + 8'h01;
        end
        // Any other reset source also ends sleep.
        if (dev_reset_req) begin
          state_nxt = gpw_pkg::ST_RUN;
        end else if (wake_hit) begin
          state_nxt = gpw_pkg::ST_WAKE;
        end
      end
      gpw_pkg::ST_WAKE: begin
        // One cycle of device reset, then running again.
        state_nxt = gpw_pkg::ST_RUN;
      end
      default: begin
        state_nxt = gpw_pkg::ST_RUN;
      end
    endcase
  end

  // Sleep controller registers.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= gpw_pkg::ST_RUN;
      ref_r      <= 4'h0;
      armed_r    <= 1'b0;
      ramp_cnt_r <= 8'h00;
    end else begin
      state_r    <= state_nxt;
      ref_r      <= ref_nxt;
      armed_r    <= armed_nxt;
      ramp_cnt_r <= ramp_cnt_nxt;
    end
  end

  // Reset-cause flags; later assignments take priority.
  always_comb begin
    wake_flag_nxt  = wake_flag_r;
    timeout_nxt    = timeout_r;
    power_down_nxt = power_down_r;
    // Clearing the watchdog marks normal running.
    if (clrwdt_exec) begin
      timeout_nxt    = 1'b1;
      power_down_nxt = 1'b1;
    end
    if (sleep_exec && (state_r == gpw_pkg::ST_RUN)) begin
      wake_flag_nxt  = 1'b1;
      timeout_nxt    = 1'b1;
      power_down_nxt = 1'b0;
    end
    // A timeout beats a watchdog clear in the same cycle, so the cause
    // of the reset that follows is never hidden from software.
    // timeout clears flag.
    if (wdt_timeout) begin
      timeout_nxt = 1'b0;
    end
    if (wake_hit) begin
      wake_flag_nxt = 1'b0;
    end
  end

  // Flags survive every reset except power-on, which sets all three.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // All three set is how software recognises a power-up.
      wake_flag_r  <= 1'b1;
      timeout_r    <= 1'b1;
      power_down_r <= 1'b1;
    end else begin
      wake_flag_r  <= wake_flag_nxt;
      timeout_r    <= timeout_nxt;
      power_down_r <= power_down_nxt;
    end
  end

  // Outputs straight from registers.
  assign reg_rdata       = rdata_r;
  assign feature_options = opt_r;
  assign asleep          = (state_r == gpw_pkg::ST_SLEEP);
  assign wake_reset      = (state_r == gpw_pkg::ST_WAKE);
endmodule

/* tb/gpw_top_asserts.sv */
// Purpose: Port, direction, option and sleep checks on the gpw_top ports.
// Assumes: One clock domain, mclk, with rst_n as an async active-low reset.
// Notes:   Bound into every gpw_top instance at the foot of this file.
`timescale 1ns/10ps
module gpw_top_asserts (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       dev_reset_req,
  input wire logic [4:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       dir_load,
  input wire logic [2:0] dir_sel,
  input wire logic [7:0] work_reg,
  input wire logic       sleep_exec,
  input wire logic [3:0] narrow_pins_out,
  input wire logic [3:0] narrow_pins_oe,
  input wire logic [7:0] wide_pins_out,
  input wire logic [7:0] wide_pins_oe,
  input wire logic [5:0] feature_options,
  input wire logic       asleep,
  input wire logic       wake_reset
);
  // Every check samples on the rising edge and rests while reset is low.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_rst_dir; dev_reset_req |=> narrow_pins_oe == 4'h0 && wide_pins_oe == 8'h00;
  endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("drivers on after reset");
  property p_wake; wake_reset |=> wide_pins_oe == 8'h00 && !wake_reset && !asleep; endproperty
  a_wake: assert property (p_wake) else $error("wake reset pulse wrong");
  property p_wr_wide; reg_wr && reg_addr == gpw_pkg::ADDR_WIDE
    |=> wide_pins_out == $past(reg_wdata); endproperty
  a_wr_wide: assert property (p_wr_wide) else $error("wide latch not written");
  property p_wr_narrow; reg_wr && reg_addr == gpw_pkg::ADDR_NARROW
    |=> narrow_pins_out == $past(reg_wdata[3:0]); endproperty
  a_wr_narrow: assert property (p_wr_narrow) else $error("narrow latch not written");
  property p_hold; !reg_wr |=> $stable(wide_pins_out); endproperty
  a_hold: assert property (p_hold) else $error("wide latch changed unwritten");
  property p_dir_wide; dir_load && dir_sel == gpw_pkg::SEL_WIDE_DIR && !dev_reset_req &&
    !wake_reset |=> wide_pins_oe == ~$past(work_reg); endproperty
  a_dir_wide: assert property (p_dir_wide) else $error("wide direction load wrong");
  property p_dir_narrow; dir_load && dir_sel == gpw_pkg::SEL_NARROW_DIR && !dev_reset_req &&
    !wake_reset |=> narrow_pins_oe == ~$past(work_reg[3:0]); endproperty
  a_dir_narrow: assert property (p_dir_narrow) else $error("narrow direction wrong");
  property p_opt; dir_load && dir_sel == gpw_pkg::SEL_OPTION && !dev_reset_req
    |=> feature_options == $past(work_reg[5:0]); endproperty
  a_opt: assert property (p_opt) else $error("option load wrong");
  property p_sleep; sleep_exec && !asleep && !wake_reset && !dev_reset_req |=> asleep;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep not entered");
  property p_quiet; asleep && (feature_options[gpw_pkg::OPT_WAKE_DIS] ||
    (&wide_pins_oe[3:0] && wide_pins_oe[7])) |=> !wake_reset; endproperty
  a_quiet: assert property (p_quiet) else $error("wake while not armed");
endmodule

bind gpw_top gpw_top_asserts gpw_top_asserts_inst (
  .mclk(mclk), .rst_n(rst_n), .dev_reset_req(dev_reset_req), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .dir_load(dir_load), .dir_sel(dir_sel),
  .work_reg(work_reg), .sleep_exec(sleep_exec), .narrow_pins_out(narrow_pins_out),
  .narrow_pins_oe(narrow_pins_oe), .wide_pins_out(wide_pins_out),
  .wide_pins_oe(wide_pins_oe), .feature_options(feature_options), .asleep(asleep),
  .wake_reset(wake_reset)
);

/* tb/gpw_pins_model.sv */
// Purpose: Outside circuitry seen by the two ports of gpw_top.
// Assumes: The bench holds every outside level firm, never floating.
// Notes:   fight lets a strong outside source overpower a driving wide pin.
`timescale 1ns/10ps
module gpw_pins_model (
  input  wire logic [3:0] narrow_out,
  input  wire logic [3:0] narrow_oe,
  input  wire logic [3:0] narrow_ext,
  output logic      [3:0] narrow_in,
  input  wire logic [7:0] wide_out,
  input  wire logic [7:0] wide_oe,
  input  wire logic [7:0] wide_ext,
  input  wire logic [7:0] wide_fight,
  output logic      [7:0] wide_in
);
  // firm pin levels
  // A pin shows its own driver where enabled and not fought, else the outside level.
  assign narrow_in = (narrow_oe & narrow_out) | (~narrow_oe & narrow_ext);
  assign wide_in = (wide_oe & ~wide_fight & wide_out) | ((~wide_oe | wide_fight) & wide_ext);
endmodule

/* tb/gpw_top_tb.sv */
// Purpose: Self-checking bench for gpw_top ports, flags, sleep and wake.
// Assumes: Pins reach the design through gpw_pins_model.
// Notes:   Pin reads wait three edges after a pin change for the synchroniser.
`timescale 1ns/10ps
module gpw_top_tb;
  logic       mclk, rst_n, dev_reset_req, reg_wr, reg_rd, dir_load, sleep_exec;
  logic       clrwdt_exec, wdt_timeout;
  logic [4:0] reg_addr;
  logic [2:0] dir_sel;
  logic [7:0] reg_wdata, reg_rdata, core_status_bits, work_reg, w_in, w_out, w_oe;
  logic [7:0] w_ext, w_fight, lw, dw, rd_v;
  logic [3:0] n_in, n_out, n_oe, n_ext, ln, dn;
  logic [5:0] feature_options;
  logic       asleep, wake_reset;
  int         n_errors, n_tests;

  gpw_top #(.RAMP_FILT(3)) gpw_top_inst (
    .mclk(mclk), .rst_n(rst_n), .dev_reset_req(dev_reset_req), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .core_status_bits(core_status_bits), .dir_load(dir_load), .dir_sel(dir_sel),
    .work_reg(work_reg), .sleep_exec(sleep_exec), .clrwdt_exec(clrwdt_exec),
    .wdt_timeout(wdt_timeout),
    .narrow_pins_in(n_in), .narrow_pins_out(n_out), .narrow_pins_oe(n_oe),
    .wide_pins_in(w_in), .wide_pins_out(w_out), .wide_pins_oe(w_oe),
    .feature_options(feature_options), .asleep(asleep), .wake_reset(wake_reset));
  gpw_pins_model gpw_pins_model_inst (
    .narrow_out(n_out), .narrow_oe(n_oe), .narrow_ext(n_ext), .narrow_in(n_in),
    .wide_out(w_out), .wide_oe(w_oe), .wide_ext(w_ext), .wide_fight(w_fight), .wide_in(w_in));

  // The clock free-runs at 100 MHz.
  initial begin
    mclk = 1'b0;
    forever #(gpw_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
  end

  // Inputs change 1 ns after the rising edge.
  task automatic cyc(int n = 1);
    repeat (n) begin
      @(posedge mclk);
      #1;
    end
  endtask

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One request: 0 write, 1 read, 2 direction load; a gap cycle follows.
  task automatic op(int k, logic [4:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    dir_sel = a[2:0];
    work_reg = d;
    {reg_wr, reg_rd, dir_load} = {k == 0, k == 1, k == 2};
    cyc();
    rd_v = reg_rdata;
    {reg_wr, reg_rd, dir_load} = 3'b000;
    cyc();
  endtask

  // Pin levels as read: latch where driving, outside level where input.
  function automatic logic [7:0] pins(logic [7:0] l, logic [7:0] d, logic [7:0] e);
    return (l & ~d) | (e & d);
  endfunction
  // Status byte with the wake, timeout and power-down flags in place.
  function automatic logic [7:0] stat(logic [7:0] c, logic [2:0] f);
    return {f[2], c[6:5], f[1:0], c[2:0]};
  endfunction

  // Sleeps, disturbs the pins, then waits a bounded time for a wake reset.
  task automatic nap(string nm, logic [7:0] opt, logic [7:0] d, logic [7:0] flip,
                     logic [7:0] fg, logic exp_w);
    int seen;
    seen = 0;
    op(2, {2'h0, gpw_pkg::SEL_OPTION}, opt);
    op(2, {2'h0, gpw_pkg::SEL_WIDE_DIR}, d);
    chk("options", {2'h0, feature_options}, opt & 8'h3f);
    cyc(2);
    sleep_exec = 1'b1;
    cyc();
    sleep_exec = 1'b0;
    chk("asleep", {7'h0, asleep}, 8'h01);
    cyc(3);
    w_ext = w_ext ^ flip;
    w_fight = fg;
    for (int i = 0; i < 40 && seen == 0; i++) begin
      cyc();
      if (wake_reset === 1'b1) seen = 1;
    end
    chk("wake", 8'(seen), {7'h0, exp_w});
    if (exp_w && seen == 0) wrap_up();
    // Leaving sleep without a wake needs an ordinary device reset.
    if (!exp_w) begin
      dev_reset_req = 1'b1;
      cyc();
      dev_reset_req = 1'b0;
    end
    cyc(2);
    w_fight = 8'h00;
    chk("wide_oe", w_oe, 8'h00);
    op(1, gpw_pkg::ADDR_STATUS, 8'h00);
    chk("status", rd_v, stat(core_status_bits, {~exp_w, 2'b10}));
    $display("test %s done", nm);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    repeat (50000) @(posedge mclk);
    n_errors++;
    wrap_up();
  end

  // Main sequence.
  initial begin
    {rst_n, dev_reset_req, reg_wr, reg_rd, dir_load, sleep_exec} = 6'h00;
    {clrwdt_exec, wdt_timeout} = 2'b00;
    {reg_addr, dir_sel, reg_wdata, work_reg, w_fight, n_ext} = '0;
    n_errors = 0;
    n_tests = 0;
    w_ext = 8'h00;
    void'($urandom(32'h0f7115a0));
    core_status_bits = 8'($urandom);
    cyc(12);
    rst_n = 1'b1;
    cyc();
    chk("wide_oe", w_oe, 8'h00);
    chk("narrow_oe", {4'h0, n_oe}, 8'h00);
    chk("options", {2'h0, feature_options}, {2'h0, gpw_pkg::OPT_RESET});
    op(1, gpw_pkg::ADDR_STATUS, 8'h00);
    chk("status", rd_v, stat(core_status_bits, 3'b111));
    op(1, 5'h1f, 8'h00);
    chk("unmapped", rd_v, 8'h00);
    // Watchdog timeout clears the timeout flag; a watchdog clear restores both.
    wdt_timeout = 1'b1;
    cyc();
    wdt_timeout = 1'b0;
    op(1, gpw_pkg::ADDR_STATUS, 8'h00);
    chk("status_wdt", rd_v, stat(core_status_bits, 3'b101));
    clrwdt_exec = 1'b1;
    cyc();
    clrwdt_exec = 1'b0;
    op(1, gpw_pkg::ADDR_STATUS, 8'h00);
    chk("status_clr", rd_v, stat(core_status_bits, 3'b111));
    $display("test reset done");
    // Random latches, directions and outside levels, all-in and all-out first.
    for (int i = 0; i < 12; i++) begin
      {lw, dw, ln, dn, w_ext, n_ext} = {8'($urandom), 8'($urandom), 8'($urandom),
                                        8'($urandom), 4'($urandom)};
      if (i < 2) {dw, dn} = (i == 0) ? 12'hfff : 12'h000;
      op(0, gpw_pkg::ADDR_WIDE, lw);
      op(0, gpw_pkg::ADDR_NARROW, {4'($urandom), ln});
      op(2, {2'h0, gpw_pkg::SEL_WIDE_DIR}, dw);
      op(2, {2'h0, gpw_pkg::SEL_NARROW_DIR}, {4'($urandom), dn});
      cyc(2);
      chk("wide_out", w_out, lw);
      chk("wide_oe", w_oe, ~dw);
      chk("narrow_out", {4'h0, n_out}, {4'h0, ln});
      chk("narrow_oe", {4'h0, n_oe}, {4'h0, ~dn});
      op(1, gpw_pkg::ADDR_WIDE, 8'h00);
      chk("wide_read", rd_v, pins(lw, dw, w_ext));
      lw = pins(lw, dw, w_ext) | (8'h01 << $urandom_range(7, 0));
      op(0, gpw_pkg::ADDR_WIDE, rd_v | (lw ^ rd_v));
      chk("bit_set", w_out, lw);
      op(1, gpw_pkg::ADDR_NARROW, 8'h00);
      chk("narrow_read", rd_v, pins({4'h0, ln}, {4'hf, dn}, {4'h0, n_ext}));
      if (i == 5) begin
        dev_reset_req = 1'b1;
        cyc();
        dev_reset_req = 1'b0;
        cyc();
        chk("reset_oe", w_oe | {4'h0, n_oe}, 8'h00);
        chk("reset_latch", w_out, lw);
      end
    end
    $display("test ports done");
    w_ext = 8'($urandom) & 8'h7f;
    nap("wake_off", 8'h3f, 8'hff, 8'h01 << $urandom_range(3, 0), 8'h00, 1'b0);
    w_ext[0] = ~w_out[0];
    nap("wake_output", 8'h1f, 8'hfe, 8'h00, 8'h01, 1'b0);
    nap("wake_pin", 8'h1f, 8'hff, 8'h01 << $urandom_range(3, 0), 8'h00, 1'b1);
    w_ext[7] = 1'b0;
    nap("wake_ramp", 8'h1f, 8'hff, 8'h80, 8'h00, 1'b1);
    wrap_up();
  end
endmodule
